// File: hw/pic_priority_interrupt_controller.v
// How it works
// [R01] Four 16-bit priority registers each hold four 4-bit module fields.
// [R02] Field value 15 is the highest level; zero masks the module.
// [R03] Priority registers A-C reset to zero, D to its fixed default; standby keeps them.
// [R04] Control register is cleared only by reset and kept through standby.
// [R05] Control bit 15 reads the nonmaskable pin level; writes ignored.
// [R06] Control bit 14 masks all interrupts except the nonmaskable one while the nonmaskable pin is low.
// [R07] Control bit 9 picks hold-pending or pass-through of nonmaskable under block bit.
// [R08] Control bit 8 picks falling or rising edge for nonmaskable detection.
// [R09] Control bit 7 picks level-encoded or four independent external pins.
// [R10] Reserved bits read zero; software writes zero there.
// [R11] Extra 32-bit priority register holds eight fields, resets to zero.
// [R12] Read-only pending register shows raw requests regardless of any mask.
// [R13] Source mask resets to low ten bits set; zero bits in writes ignored.
// [R14] Ones written to the mask-clear register clear matching mask bits.
// [R15] Highest programmed level wins; others stay pending.
// [R16] Ties are broken by a fixed source order.
// [R17] CPU is signalled only when winning level exceeds its mask level.
// [R18] CPU latches event code, saves status and PC, jumps to vector base plus 0x600.
// [R19] Accepting an interrupt leaves the CPU mask level unchanged.
// [R20] Software clears and rereads the source flag before unblocking.
// [R21] Every source has a distinct event code presented with the request.
// [R22] Edge detection is suppressed for six cycles after edge select changes.
// [R23] External pins count only after three equal consecutive samples.
// [R24] Level-encoded pin code 0000 is level 15, 1111 no request.
// [R25] Writing one to a mask bit masks that source but pending still shows.
// [R26] CPU request carries the winner level and drops when the source drops.
`include "pic_defines.vh"

module pic_priority_interrupt_controller (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [15:0] periphReq,
    input wire [31:0] extraReq,
    input wire nonmaskablePin,
    input wire [3:0] externalRequestPinsN,
    input wire [3:0] cpuMaskLevel,
    input wire blockBit,
    input wire cpuAccept,
    output wire cpuIrq,
    output wire cpuIrqNmi,
    output wire [3:0] cpuIrqLevel,
    output wire [11:0] eventCode
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and bus handshake.

    reg [15:0] prioA_r;
    reg [15:0] prioB_r;
    reg [15:0] prioC_r;
    reg [15:0] prioD_r;
    reg [15:0] ctrl_r;
    reg [31:0] extraPrio_r;
    reg [31:0] pending_r;
    reg [31:0] srcMask_r;
    reg [31:0] prdata_r;
    reg [31:0] prdata_nxt;
    reg pready_r;
    reg pslverr_r;
    reg pslverr_nxt;
    reg nmiLevel_r;

    wire setupPhase = psel & ~penable;
    wire wrStrobe = psel & penable & pready_r & pwrite;

    // Read data and the error answer are prepared in the setup cycle.
    always @* begin
        prdata_nxt = 32'h00000000;
        pslverr_nxt = 1'b0;
        if (paddr == `PIC_OFS_PRIO_A) begin
            prdata_nxt = {16'h0000, prioA_r}; // R10
        end else if (paddr == `PIC_OFS_PRIO_B) begin
            prdata_nxt = {16'h0000, prioB_r};
        end else if (paddr == `PIC_OFS_PRIO_C) begin
            prdata_nxt = {16'h0000, prioC_r};
        end else if (paddr == `PIC_OFS_PRIO_D) begin
            prdata_nxt = {16'h0000, prioD_r};
        end else if (paddr == `PIC_OFS_CTRL) begin
            prdata_nxt = {16'h0000, nmiLevel_r, ctrl_r[14:0]}; // R05 R10
        end else if (paddr == `PIC_OFS_EXTRA_PRIO) begin
            prdata_nxt = extraPrio_r;
        end else if (paddr == `PIC_OFS_PENDING) begin
            prdata_nxt = pending_r; // R12
        end else if (paddr == `PIC_OFS_MASK) begin
            prdata_nxt = srcMask_r;
        end else if (paddr == `PIC_OFS_MASK_CLR) begin
            prdata_nxt = 32'h00000000;
        end else begin
            pslverr_nxt = 1'b1;
        end
    end

    // A zero-wait slave: pready rises in the access cycle that follows every setup.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setupPhase;
            pslverr_r <= setupPhase & pslverr_nxt;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_r <= 32'h00000000;
        end else if (setupPhase && !pwrite) begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Only reset initialises these; no standby input exists to touch them.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prioA_r <= `PIC_RST_PRIO_ABC; // R03
        end else if (wrStrobe && paddr == `PIC_OFS_PRIO_A) begin
            prioA_r <= pwdata[15:0]; // R01
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prioB_r <= `PIC_RST_PRIO_ABC;
        end else if (wrStrobe && paddr == `PIC_OFS_PRIO_B) begin
            prioB_r <= pwdata[15:0];
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prioC_r <= `PIC_RST_PRIO_ABC;
        end else if (wrStrobe && paddr == `PIC_OFS_PRIO_C) begin
            prioC_r <= pwdata[15:0];
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prioD_r <= `PIC_RST_PRIO_D;
        end else if (wrStrobe && paddr == `PIC_OFS_PRIO_D) begin
            prioD_r <= pwdata[15:0];
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `PIC_RST_CTRL; // R04
        end else if (wrStrobe && paddr == `PIC_OFS_CTRL) begin
            ctrl_r <= pwdata[15:0] & `PIC_CTRL_WR_MASK; // R05 R10
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            extraPrio_r <= `PIC_RST_EXTRA_PRIO; // R11
        end else if (wrStrobe && paddr == `PIC_OFS_EXTRA_PRIO) begin
            extraPrio_r <= pwdata; // R11
        end
    end

    // Set and clear share one register, so both addresses are decoded in one process.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            srcMask_r <= `PIC_RST_MASK; // R13
        end else if (wrStrobe && paddr == `PIC_OFS_MASK) begin
            srcMask_r <= srcMask_r | pwdata; // R13 R25
        end else if (wrStrobe && paddr == `PIC_OFS_MASK_CLR) begin
            srcMask_r <= srcMask_r & ~pwdata; // R14
        end
    end

    wire maskAllOnLow = ctrl_r[`PIC_CTRL_MASK_ALL];
    wire blockHold = ctrl_r[`PIC_CTRL_BLOCK_HOLD];
    wire edgeSel = ctrl_r[`PIC_CTRL_EDGE_SEL];
    wire pinMode = ctrl_r[`PIC_CTRL_PIN_MODE];

    ////////////////////////////////////////////////////////////////////////////////
    // Nonmaskable input: edge detection with blackout after edge select changes.

    reg nmiPrev_r;
    reg [2:0] blackout_r;
    reg nmiPend_r;

    wire edgeSelWrite = wrStrobe & (paddr == `PIC_OFS_CTRL) & (pwdata[`PIC_CTRL_EDGE_SEL] != edgeSel);
    wire nmiEdge = edgeSel ? (nonmaskablePin & ~nmiPrev_r) : (~nonmaskablePin & nmiPrev_r); // R08
    wire nmiDetect = nmiEdge & (blackout_r == 3'h0); // R22
    wire nmiPass = nmiPend_r & ~(blockBit & ~blockHold); // R07
    wire nmiWin;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nmiLevel_r <= 1'b0;
            nmiPrev_r <= 1'b0;
        end else begin
            nmiLevel_r <= nonmaskablePin; // R05
            nmiPrev_r <= nonmaskablePin;
        end
    end

    // Any write that flips the edge select starts the blackout again.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blackout_r <= 3'h0;
        end else if (edgeSelWrite) begin
            blackout_r <= `PIC_EDGE_BLACKOUT; // R22
        end else if (blackout_r != 3'h0) begin
            blackout_r <= blackout_r - 3'h1;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nmiPend_r <= 1'b0;
        // A new edge in the accept cycle keeps the request pending.
        end else if (nmiDetect) begin
            nmiPend_r <= 1'b1;
        end else if (cpuAccept && nmiWin) begin
            nmiPend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External request pins: three-sample noise filter.

    reg [3:0] pinS0_r;
    reg [3:0] pinS1_r;
    reg [3:0] pinS2_r;
    reg [3:0] pinFilt_r;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinS0_r <= 4'hf;
            pinS1_r <= 4'hf;
            pinS2_r <= 4'hf;
            pinFilt_r <= 4'hf;
        end else begin
            pinS0_r <= externalRequestPinsN;
            pinS1_r <= pinS0_r;
            pinS2_r <= pinS1_r;
            if (pinS0_r == pinS1_r && pinS1_r == pinS2_r) begin
                pinFilt_r <= pinS2_r; // R23
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-source levels, flattened in fixed tie order.

    wire maskAll = maskAllOnLow & ~nonmaskablePin; // R06
    wire [`PIC_NUM_SRC*5-1:0] srcLvl;
    wire [63:0] periphPrio = {prioD_r, prioC_r, prioB_r, prioA_r};
    wire [15:0] extIndLvl = `PIC_EXT_IND_LEVELS;

    // Nonmaskable requests sit at level 16, above any programmable level.
    assign srcLvl[4:0] = nmiPass ? 5'h10 : 5'h00;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : genExt
            wire [3:0] lvl;
            if (g == 0) begin : genEnc
                assign lvl = pinMode ? (pinFilt_r[0] ? 4'h0 : extIndLvl[3:0]) : (4'hf - pinFilt_r); // R09 R24
            end else begin : genInd
                assign lvl = (pinMode && !pinFilt_r[g]) ? extIndLvl[g*4+3:g*4] : 4'h0; // R09
            end
            assign srcLvl[(g+1)*5+4:(g+1)*5] = maskAll ? 5'h00 : {1'b0, lvl};
        end

        for (g = 0; g < 16; g = g + 1) begin : genPeriph
            wire act = periphReq[g] & ~maskAll;
            assign srcLvl[(g+`PIC_IDX_PERIPH)*5+4:(g+`PIC_IDX_PERIPH)*5] =
                act ? {1'b0, periphPrio[g*4+3:g*4]} : 5'h00; // R01 R02
        end

        for (g = 0; g < 32; g = g + 1) begin : genExtra
            wire act = extraReq[g] & ~srcMask_r[g] & ~maskAll; // R25
            assign srcLvl[(g+`PIC_IDX_EXTRA)*5+4:(g+`PIC_IDX_EXTRA)*5] =
                act ? {1'b0, extraPrio_r[(g/4)*4+3:(g/4)*4]} : 5'h00; // R11 R02
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Arbitration and CPU request.

    reg [4:0] bestLvl;
    reg [5:0] bestIdx;
    integer j;

    // Walking from the last source down with >= leaves the lowest index on ties.
    always @* begin
        bestLvl = 5'h00;
        bestIdx = 6'h00;
        for (j = `PIC_NUM_SRC - 1; j >= 0; j = j - 1) begin
            if (srcLvl[j*5 +: 5] != 5'h00 && srcLvl[j*5 +: 5] >= bestLvl) begin
                bestLvl = srcLvl[j*5 +: 5]; // R15
                bestIdx = j[5:0]; // R16
            end
        end
    end

    assign nmiWin = (bestLvl == 5'h10);
    wire raise = nmiWin | (bestLvl != 5'h00 && bestLvl[3:0] > cpuMaskLevel); // R17

    reg cpuIrq_r;
    reg cpuIrqNmi_r;
    reg [3:0] cpuIrqLevel_r;
    reg [11:0] eventCode_r;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pending_r <= 32'h00000000;
        end else begin
            pending_r <= extraReq; // R12
        end
    end

    // The request outputs are registered so the CPU sees one settled code per cycle.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpuIrq_r <= 1'b0;
        end else begin
            cpuIrq_r <= raise; // R26
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpuIrqNmi_r <= 1'b0;
        end else begin
            cpuIrqNmi_r <= raise & nmiWin;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpuIrqLevel_r <= 4'h0;
        end else begin
            cpuIrqLevel_r <= raise ? (nmiWin ? 4'hf : bestLvl[3:0]) : 4'h0; // R26
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eventCode_r <= `PIC_EVT_NONE;
        end else begin
            eventCode_r <= raise ? (`PIC_EVT_BASE + {1'b0, bestIdx, 5'h00}) : `PIC_EVT_NONE; // R21
        end
    end

    assign cpuIrq = cpuIrq_r;
    assign cpuIrqNmi = cpuIrqNmi_r;
    assign cpuIrqLevel = cpuIrqLevel_r;
    assign eventCode = eventCode_r;

endmodule

// File: hw/pic_defines.vh
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH

// Register byte offsets on the APB.
`define PIC_OFS_PRIO_A 8'h00
`define PIC_OFS_PRIO_B 8'h04
`define PIC_OFS_PRIO_C 8'h08
`define PIC_OFS_PRIO_D 8'h0c
`define PIC_OFS_CTRL 8'h10
`define PIC_OFS_EXTRA_PRIO 8'h14
`define PIC_OFS_PENDING 8'h18
`define PIC_OFS_MASK 8'h1c
`define PIC_OFS_MASK_CLR 8'h20

// Reset values.
`define PIC_RST_PRIO_ABC 16'h0000
`define PIC_RST_PRIO_D 16'hda74
`define PIC_RST_CTRL 16'h0000
`define PIC_RST_EXTRA_PRIO 32'h00000000
`define PIC_RST_MASK 32'h000003ff

// Control register field positions and writable bits.
`define PIC_CTRL_PIN_LEVEL 15
`define PIC_CTRL_MASK_ALL 14
`define PIC_CTRL_BLOCK_HOLD 9
`define PIC_CTRL_EDGE_SEL 8
`define PIC_CTRL_PIN_MODE 7
`define PIC_CTRL_WR_MASK 16'h4380

// Edge detection blackout after the edge select changes, in bus cycles.
`define PIC_EDGE_BLACKOUT 3'h6

// Source numbering for arbitration; a lower index wins a tie.
`define PIC_NUM_SRC 53
`define PIC_IDX_NMI 6'h00
`define PIC_IDX_EXT 6'h01
`define PIC_IDX_PERIPH 5
`define PIC_IDX_EXTRA 21

// Levels used by the four independent external pins.
`define PIC_EXT_IND_LEVELS 16'h47ad

// Event codes: base plus source index times 32.
`define PIC_EVT_BASE 12'h200
`define PIC_EVT_NONE 12'h000

`endif

// File: test/pic_checker.sv
module pic_checker (
    input wire clk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire nonmaskablePin,
    input wire [3:0] cpuMaskLevel,
    input wire cpuIrq,
    input wire cpuIrqNmi,
    input wire [3:0] cpuIrqLevel,
    input wire [11:0] eventCode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire setup = psel && !penable;
    wire rdCtrl = pready && !pwrite && paddr == 8'h10;
    ////////////////////////////////////////////////////////////////
    chk_ready_slot: assert property (pready == $past(setup))
        else $error("pready outside the access cycle");
    chk_err_map: assert property (pready |-> pslverr == (paddr > 8'h20 || paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    chk_ctrl_zero: assert property (rdCtrl |-> prdata[31:16] == 16'h0 && prdata[13:10] == 4'h0 && prdata[6:0] == 7'h0)
        else $error("control reserved bits not zero");
    chk_pin_read: assert property (rdCtrl |-> prdata[15] == $past(nonmaskablePin, 2))
        else $error("control bit 15 not the pin level");
    chk_irq_above: assert property (cpuIrq && !cpuIrqNmi |-> cpuIrqLevel > $past(cpuMaskLevel))
        else $error("request level not above cpu mask");
    chk_idle_zero: assert property (!cpuIrq |-> cpuIrqLevel == 4'h0 && eventCode == 12'h0 && !cpuIrqNmi)
        else $error("idle request outputs not zero");
    chk_evt_code: assert property (cpuIrq |-> eventCode[4:0] == 5'h0 && eventCode >= 12'h200 && eventCode <= 12'h880)
        else $error("event code outside source table");
    chk_nmi_top: assert property (cpuIrqNmi |-> cpuIrq && cpuIrqLevel == 4'hf && eventCode == 12'h200)
        else $error("nonmaskable request wrongly coded");
    cover property (cpuIrqNmi);
    cover property (pready && pslverr);
    cover property (cpuIrq && cpuIrqLevel == 4'h9);
endmodule

bind pic_priority_interrupt_controller pic_checker i_pic_checker (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nonmaskablePin(nonmaskablePin), .cpuMaskLevel(cpuMaskLevel), .cpuIrq(cpuIrq),
    .cpuIrqNmi(cpuIrqNmi), .cpuIrqLevel(cpuIrqLevel), .eventCode(eventCode)
);

// File: test/pic_cpu_model.sv
module pic_cpu_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] lat,
    input wire logic cpuIrq,
    input wire logic [11:0] eventCode,
    output logic blockBit,
    output logic cpuAccept,
    output logic [11:0] evtSeen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wt;
    // The mask level is left to the bench, so accepting never changes it.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {blockBit, cpuAccept, wt, evtSeen} <= '0;
        end else begin
            cpuAccept <= 1'b0;
            wt <= (cpuIrq && !blockBit) ? wt + 3'h1 : 3'h0;
            if (cpuIrq && !blockBit && wt == lat)
                cpuAccept <= 1'b1;
            if (cpuAccept) begin
                evtSeen <= eventCode;
                blockBit <= 1'b1;
            end else if (!cpuIrq) begin
                blockBit <= 1'b0;
            end
        end
    end
endmodule

// File: test/test_priority_interrupt_controller.sv
module test_priority_interrupt_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, psel, penable, pwrite, nonmaskablePin;
    logic [7:0] paddr;
    logic [31:0] pwdata, extraReq, seed;
    logic [15:0] periphReq;
    logic [3:0] externalRequestPinsN, cpuMaskLevel;
    logic [2:0] lat;
    wire [31:0] prdata;
    wire [11:0] eventCode;
    wire [3:0] cpuIrqLevel;
    wire pready, pslverr, cpuIrq, cpuIrqNmi, blockBit, cpuAccept;
    logic [31:0] qr[$];
    logic [15:0] qi[$];
    int n_mismatch, tests_run, cyc;
    logic [7:0] ofs[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
    logic [31:0] rv[10] = '{32'h0, 32'h0, 32'h0, 32'hda74, 32'h0, 32'h0, 32'h0, 32'h3ff, 32'h0, 32'h0};
    pic_priority_interrupt_controller i_pic_priority_interrupt_controller (.clk(clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periphReq(periphReq), .extraReq(extraReq),
        .nonmaskablePin(nonmaskablePin), .externalRequestPinsN(externalRequestPinsN),
        .cpuMaskLevel(cpuMaskLevel), .blockBit(blockBit), .cpuAccept(cpuAccept), .cpuIrq(cpuIrq),
        .cpuIrqNmi(cpuIrqNmi), .cpuIrqLevel(cpuIrqLevel), .eventCode(eventCode));
    pic_cpu_model i_pic_cpu_model (.clk(clk), .nrst(nrst), .lat(lat), .cpuIrq(cpuIrq),
        .eventCode(eventCode), .blockBit(blockBit), .cpuAccept(cpuAccept), .evtSeen());
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // For a read, d is the expected word.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        if (!w)
            qr.push_back(d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 20);
        {psel, penable} <= 2'b00;
    endtask
    task automatic irq(input logic [15:0] e);
        int n;
        qi.push_back(e);
        n = 0;
        while (qi.size() != 0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("irq wait", qi.size(), 32'h0);
    endtask
    task automatic quiet();
        repeat (8) @(posedge clk);
        chk("cpuIrq idle", cpuIrq, 32'h0);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite)
            chk("prdata", prdata, qr.pop_front());
        if (cpuAccept)
            chk("accepted request", {cpuIrqLevel, eventCode}, qi.pop_front());
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {nrst, psel, penable, pwrite, nonmaskablePin, paddr, pwdata, periphReq, extraReq} = '0;
        externalRequestPinsN = 4'hf;
        cpuMaskLevel = 4'h2;
        lat = 3'h1;
        seed = lfsr(32'h7573);
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        foreach (ofs[i]) apb(1'b0, ofs[i], rv[i]);
        extraReq <= seed;
        lat <= seed[2:0];
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b0, 8'h18, seed);
        extraReq <= 32'h0;
        apb(1'b1, 8'h0c, seed);
        apb(1'b0, 8'h0c, {16'h0, seed[15:0]});
        apb(1'b1, 8'h00, 32'h0053);
        apb(1'b1, 8'h10, 32'hffff);
        repeat (8) @(posedge clk);
        nonmaskablePin <= 1'b1;
        irq(16'hf200);
        apb(1'b0, 8'h10, 32'hc380);
        nonmaskablePin <= 1'b0;
        repeat (2) @(posedge clk);
        periphReq <= 16'h3;
        quiet();
        apb(1'b1, 8'h10, 32'h0100);
        irq(16'h52c0);
        periphReq <= 16'h0;
        apb(1'b1, 8'h00, 32'h0055);
        periphReq <= 16'h3;
        irq(16'h52a0);
        cpuMaskLevel <= 4'h5;
        quiet();
        {periphReq, cpuMaskLevel} <= {16'h0, 4'h2};
        apb(1'b1, 8'h1c, 32'h0);
        apb(1'b0, 8'h1c, 32'h3ff);
        apb(1'b1, 8'h20, 32'h3fe);
        apb(1'b1, 8'h1c, 32'h4);
        apb(1'b0, 8'h1c, 32'h5);
        apb(1'b1, 8'h14, 32'h9);
        extraReq <= 32'h3;
        irq(16'h94c0);
        apb(1'b0, 8'h18, 32'h3);
        extraReq <= 32'h0;
        externalRequestPinsN <= 4'ha;
        irq(16'h5220);
        externalRequestPinsN <= 4'h0;
        repeat (2) @(posedge clk);
        externalRequestPinsN <= 4'hf;
        quiet();
        apb(1'b1, 8'h10, 32'h0180);
        externalRequestPinsN <= 4'hd;
        irq(16'ha240);
        complete_run();
    end
endmodule
